// [rtl/stopwatch_pkg.sv]
package stopwatch_pkg;

  // ----------------------------------------------------------------
  // Clock and base rate
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned BASE_HZ      = 256;
  // Rounded down, so the base tick runs very slightly fast.
  localparam int unsigned BASE_DIV_CYC = CLK_HZ / BASE_HZ;
  localparam int unsigned BASE_W       = 19;

  // ----------------------------------------------------------------
  // Register indexes; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_FLAGS   = 12'hF01;
  localparam logic [11:0] IDX_ENABLES = 12'hF11;
  localparam logic [11:0] IDX_HUND    = 12'hF22;
  localparam logic [11:0] IDX_TENTH   = 12'hF23;
  localparam logic [11:0] IDX_CTRL    = 12'hF77;
  localparam int unsigned ADR_W       = 14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BIT_TENTH_SEC = 0;
  localparam int unsigned BIT_ONE_SEC   = 1;
  localparam int unsigned BIT_GO        = 0;
  localparam int unsigned BIT_CLEAR     = 1;
  localparam logic [3:0]  DIGIT_RST     = 4'h0;
  localparam logic [3:0]  DIGIT_MAX     = 4'h9;
  localparam logic [1:0]  FLAGS_RST     = 2'h0;
  localparam logic [1:0]  ENABLES_RST   = 2'h0;

  // ----------------------------------------------------------------
  // Step pattern lengths in base periods
  // ----------------------------------------------------------------
  localparam logic [1:0]  STEP_SHORT    = 2'h2;
  localparam logic [1:0]  STEP_LONG     = 2'h3;
  localparam int unsigned CYC_SHORT     = 25;
  localparam int unsigned CYC_LONG      = 26;
  localparam int unsigned SEC_PERIODS   = 256;

endpackage : stopwatch_pkg

// [rtl/bcd_stopwatch_timer.sv]
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Two cascaded BCD digits: hundredths on a near 100 Hz tick, tenths on its carry.
// - Hundredths steps come from 256 Hz base ticks, every 2 or 3 periods.
// - A ten-step hundredths cycle lasts 25 or 26 base periods, giving the tenths carry.
// - Four 25-period and six 26-period cycles per tenths cycle give exactly 1 Hz.
// - Hundredths wrap sets the tenth-second flag; tenths wrap sets the one-second flag.
// - Flags set regardless of mask; interrupt raised only for enabled flags.
// - Enable register: bit 0 tenth-second, bit 1 one-second, readable, reset to 0.
// - Flag register: bit 0 and bit 1 flags, writes ignored, upper bits zero.
// - Reading the flag register clears its flags.
// - Writing 1 to control bit 1 zeroes both digits; the bit reads as 0.
// - Clear written with bit 0 set keeps counting from zero; with bit 0 clear, digits hold zero.
// - Control bit 0 runs or stops counting, readable, reset to 0.
// - Digit registers are read-only BCD values, reset to zero.
module bcd_stopwatch_timer #(
  parameter int unsigned BASE_DIV = stopwatch_pkg::BASE_DIV_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [13:0] wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        req;
  logic        wr;
  logic        rd;
  logic [11:0] idx;
  logic        clr_wr;
  logic        flag_rd;

  // A request is taken once; ack is registered, so every access takes one wait cycle.
  assign req     = wb_cyc & wb_stb & ~wb_ack;
  assign wr      = req & wb_we & wb_sel[0];
  assign rd      = req & ~wb_we;
  assign idx     = wb_adr[13:2];
  assign clr_wr  = wr & (idx == stopwatch_pkg::IDX_CTRL)
                   & wb_dat_w[stopwatch_pkg::BIT_CLEAR];
  assign flag_rd = rd & (idx == stopwatch_pkg::IDX_FLAGS);

  // ----------------------------------------------------------------
  // Registers of state
  // ----------------------------------------------------------------
  logic [18:0] base_cnt_reg;
  logic        base_tick_reg;
  logic [1:0]  step_cnt_reg;
  logic [3:0]  hund_reg;
  logic [3:0]  tenth_reg;
  logic        go_reg;
  logic [1:0]  flags_reg;
  logic [1:0]  enables_reg;

  // ----------------------------------------------------------------
  // Base 256 Hz divider
  // ----------------------------------------------------------------
  // The divider runs free, like the oscillator chain, so run and stop only gate the digits.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      base_cnt_reg  <= '0;
      base_tick_reg <= 1'b0;
    end else if (base_cnt_reg == 19'(BASE_DIV - 1)) begin
      base_cnt_reg  <= '0;
      base_tick_reg <= 1'b1;
    end else begin
      base_cnt_reg  <= base_cnt_reg + 19'h00001;
      base_tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Step pattern
  // ----------------------------------------------------------------
  logic       long_cyc;
  logic       long_step;
  logic [1:0] step_len;
  logic       step;
  logic       hund_wrap;
  logic       tenth_wrap;

  // Tenths values 1, 3, 6 and 8 take short cycles, the other six long ones.
  assign long_cyc  = ~(tenth_reg == 4'h1 || tenth_reg == 4'h3 ||
                       tenth_reg == 4'h6 || tenth_reg == 4'h8);
  // Odd hundredths take three periods; a long cycle adds a third period at zero.
  assign long_step = hund_reg[0] | (long_cyc & (hund_reg == 4'h0));
  assign step_len  = long_step ? stopwatch_pkg::STEP_LONG
                               : stopwatch_pkg::STEP_SHORT;
  // A clear in the same cycle wins over a step.
  assign step       = go_reg & base_tick_reg & ~clr_wr
                      & (step_cnt_reg == step_len - 2'h1);
  assign hund_wrap  = step & (hund_reg == stopwatch_pkg::DIGIT_MAX);
  assign tenth_wrap = hund_wrap & (tenth_reg == stopwatch_pkg::DIGIT_MAX);

  // Base periods within the current step; cleared with the digits.
  always_ff @(posedge sys_clk) begin
    if (!rst_b || clr_wr) begin
      step_cnt_reg <= 2'h0;
    end else if (step) begin
      step_cnt_reg <= 2'h0;
    end else if (go_reg && base_tick_reg) begin
      step_cnt_reg <= step_cnt_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // BCD digits
  // ----------------------------------------------------------------
  // Digits hold while stopped and restart at once from zero after a clear written with run set.
  always_ff @(posedge sys_clk) begin
    if (!rst_b || clr_wr) begin
      hund_reg  <= stopwatch_pkg::DIGIT_RST;
      tenth_reg <= stopwatch_pkg::DIGIT_RST;
    end else if (step) begin
      hund_reg <= hund_wrap ? 4'h0 : hund_reg + 4'h1;
      if (hund_wrap) begin
        tenth_reg <= tenth_wrap ? 4'h0 : tenth_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      go_reg      <= 1'b0;
      enables_reg <= stopwatch_pkg::ENABLES_RST;
    end else if (wr && idx == stopwatch_pkg::IDX_CTRL) begin
      go_reg <= wb_dat_w[stopwatch_pkg::BIT_GO];
    end else if (wr && idx == stopwatch_pkg::IDX_ENABLES) begin
      enables_reg <= wb_dat_w[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  logic [1:0] flag_set;

  assign flag_set[stopwatch_pkg::BIT_TENTH_SEC] = hund_wrap;
  assign flag_set[stopwatch_pkg::BIT_ONE_SEC]   = tenth_wrap;

  // Set beats the read clear, so an event landing on the read is kept for the next one.
  for (genvar i = 0; i < 2; i++) begin : g_flag
    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        flags_reg[i] <= 1'b0;
      end else if (flag_set[i]) begin
        flags_reg[i] <= 1'b1;
      end else if (flag_rd) begin
        flags_reg[i] <= 1'b0;
      end
    end
  end

  // Interrupt level, registered, so it trails the flags by one cycle.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_reg & enables_reg);
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  logic [3:0] rd_nib;

  // Unmapped addresses read zero and still get an ack.
  always_comb begin
    rd_nib = 4'h0;
    case (idx)
      stopwatch_pkg::IDX_FLAGS:   rd_nib = {2'b00, flags_reg};
      stopwatch_pkg::IDX_ENABLES: rd_nib = {2'b00, enables_reg};
      stopwatch_pkg::IDX_HUND:    rd_nib = hund_reg;
      stopwatch_pkg::IDX_TENTH:   rd_nib = tenth_reg;
      stopwatch_pkg::IDX_CTRL:    rd_nib = {3'b000, go_reg};
      default:                    rd_nib = 4'h0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wb_ack   <= 1'b0;
      wb_dat_r <= 32'h00000000;
    end else begin
      wb_ack   <= req;
      wb_dat_r <= rd ? {28'h0000000, rd_nib} : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] cyc_per_reg;
  logic [8:0] sec_per_reg;

  // Base periods counted within the current hundredths and tenths cycles.
  always_ff @(posedge sys_clk) begin
    if (!rst_b || clr_wr) begin
      cyc_per_reg <= '0;
      sec_per_reg <= '0;
    end else if (go_reg && base_tick_reg) begin
      cyc_per_reg <= hund_wrap ? 5'h00 : cyc_per_reg + 5'h01;
      sec_per_reg <= tenth_wrap ? 9'h000 : sec_per_reg + 9'h001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_digits_bcd: assert property (hund_reg <= 4'h9 && tenth_reg <= 4'h9)
    else $error("digit out of BCD range");
  a_tenth_on_carry: assert property ($changed(tenth_reg) |-> $past(hund_wrap) || $past(clr_wr))
    else $error("tenths moved without carry");
  a_step_length: assert property (step |-> (step_len == 2'h2 || step_len == 2'h3))
    else $error("bad step length");
  a_cycle_length: assert property (hund_wrap |->
      (cyc_per_reg + 5'h01 == 5'(stopwatch_pkg::CYC_SHORT)) ||
      (cyc_per_reg + 5'h01 == 5'(stopwatch_pkg::CYC_LONG)))
    else $error("hundredths cycle not 25 or 26");
  a_second_exact: assert property (tenth_wrap |->
      sec_per_reg + 9'h001 == 9'(stopwatch_pkg::SEC_PERIODS))
    else $error("tenths cycle not 256 periods");
  a_flag_on_wrap: assert property (hund_wrap |=> flags_reg[0])
    else $error("tenth-second flag not set");
  a_sec_flag_wrap: assert property (tenth_wrap |=> flags_reg[1] && tenth_reg == 4'h0)
    else $error("one-second flag not set");
  a_irq_gated: assert property (##1 irq == |($past(flags_reg) & $past(enables_reg)))
    else $error("interrupt does not follow flags and enables");
  a_read_clears: assert property (flag_rd && !hund_wrap |=> flags_reg == 2'b00)
    else $error("flag read did not clear");
  a_clear_zeroes: assert property (clr_wr |=> hund_reg == 4'h0 && tenth_reg == 4'h0)
    else $error("clear left digits nonzero");
  a_stop_holds: assert property (!go_reg && !clr_wr |=> $stable(hund_reg))
    else $error("digit moved while stopped");
  a_flag_read_high: assert property (wb_ack |-> wb_dat_r[31:4] == 28'h0000000)
    else $error("upper read bits not zero");

  // ----------------------------------------------------------------
  // Further checks
  // ----------------------------------------------------------------
  logic ctrl_wr;
  logic ena_wr;
  logic ctrl_rd;

  // Strobes for the checks only; they repeat the bus decode so a decode slip shows up.
  assign ctrl_wr = wr & (idx == stopwatch_pkg::IDX_CTRL);
  assign ena_wr  = wr & (idx == stopwatch_pkg::IDX_ENABLES);
  assign ctrl_rd = rd & (idx == stopwatch_pkg::IDX_CTRL);

  // Only a hundredths wrap may raise the tenth-second flag.
  a_tenth_flag_idle: assert property (!flags_reg[0] && !hund_wrap |=> !flags_reg[0])
    else $error("tenth-second flag rose without wrap");
  // Only a tenths wrap may raise the one-second flag.
  a_sec_flag_idle: assert property (!flags_reg[1] && !tenth_wrap |=> !flags_reg[1])
    else $error("one-second flag rose without wrap");
  // A set flag stays until software reads it, whatever the mask.
  a_tenth_flag_kept: assert property (flags_reg[0] && !flag_rd |=> flags_reg[0])
    else $error("tenth-second flag lost");
  // The one-second flag is sticky in the same way.
  a_sec_flag_kept: assert property (flags_reg[1] && !flag_rd |=> flags_reg[1])
    else $error("one-second flag lost");
  // An event that lands on the read must not be swallowed by it.
  a_set_beats_read: assert property (flag_rd && hund_wrap |=> flags_reg[0])
    else $error("read clear beat a new event");
  // With both enables off the line stays low.
  a_irq_masked: assert property (enables_reg == 2'b00 |=> !irq)
    else $error("interrupt raised while masked");
  // Any enabled flag raises the line one cycle later.
  a_irq_enabled: assert property (|(flags_reg & enables_reg) |=> irq)
    else $error("enabled flag gave no interrupt");
  // Enables change only through their own register.
  a_ena_held: assert property (!ena_wr |=> $stable(enables_reg))
    else $error("enables moved without a write");
  // A written one enables the tenth-second interrupt.
  a_ena_written: assert property (ena_wr && wb_dat_w[0] |=> enables_reg[0])
    else $error("enable write not taken");
  // Writing one to the run bit starts counting.
  a_go_set: assert property (ctrl_wr && wb_dat_w[0] |=> go_reg)
    else $error("run bit not set");
  // Writing zero to the run bit stops counting.
  a_go_cleared: assert property (ctrl_wr && !wb_dat_w[0] |=> !go_reg)
    else $error("run bit not cleared");
  // The run bit holds between control writes.
  a_go_held: assert property (!ctrl_wr |=> $stable(go_reg))
    else $error("run bit moved without a write");
  // The tenths digit holds while stopped.
  a_tenth_stopped: assert property (!go_reg && !clr_wr |=> $stable(tenth_reg))
    else $error("tenths moved while stopped");
  // A step below nine adds exactly one.
  a_hund_advance: assert property (step && !hund_wrap |=> hund_reg == $past(hund_reg) + 4'h1)
    else $error("hundredths did not count by one");
  // A carry below nine adds exactly one to the tenths.
  a_tenth_advance: assert property (hund_wrap && !tenth_wrap |=> tenth_reg == $past(tenth_reg) + 4'h1)
    else $error("tenths did not count by one");
  // Nine wraps to zero.
  a_hund_wraps_zero: assert property (hund_wrap |=> hund_reg == 4'h0)
    else $error("hundredths did not wrap to zero");
  // Steps happen only on a base tick.
  a_step_on_tick: assert property (step |-> base_tick_reg)
    else $error("step without base tick");
  // The base tick is a single-cycle pulse.
  a_tick_single: assert property (base_tick_reg |=> !base_tick_reg)
    else $error("base tick longer than one cycle");
  // Short hundredths cycles fall only on tenths values 1, 3, 6 and 8.
  a_short_tenths: assert property (hund_wrap && cyc_per_reg == 5'(stopwatch_pkg::CYC_SHORT - 1) |->
      (tenth_reg == 4'h1 || tenth_reg == 4'h3 || tenth_reg == 4'h6 || tenth_reg == 4'h8))
    else $error("short cycle at wrong tenths value");
  // A clear written with run set restarts from zero at once.
  a_clear_restarts: assert property (clr_wr && wb_dat_w[0] |=> go_reg && hund_reg == 4'h0)
    else $error("clear while running did not restart");
  // The clear bit and the unused bits read back as zero.
  a_ctrl_reads: assert property (wb_ack && $past(ctrl_rd) |-> wb_dat_r[3:1] == 3'b000)
    else $error("control read shows write-only bits");
  // Unused flag bits read as zero.
  a_flag_upper: assert property (wb_ack && $past(flag_rd) |-> wb_dat_r[3:2] == 2'b00)
    else $error("flag register upper bits set");
  // Ack is a single-cycle pulse.
  a_ack_single: assert property (wb_ack |=> !wb_ack)
    else $error("ack held longer than one cycle");
  // Every new request is answered in the next cycle.
  a_ack_answers: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("request not acknowledged");
  // Writes return zero data.
  a_write_no_data: assert property (wb_ack && $past(wb_we) |-> wb_dat_r == 32'h00000000)
    else $error("write returned data");

endmodule : bcd_stopwatch_timer

`default_nettype wire

// [verif/bcd_stopwatch_timer_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module bcd_stopwatch_timer_tb;

  // ----------------------------------------------------------------
  // Settings and signals
  // ----------------------------------------------------------------
  // A short base division keeps one full second near a thousand cycles.
  localparam int unsigned BD    = 4;
  localparam int          LIMIT = 6000;
  localparam logic [11:0] A_FLG = stopwatch_pkg::IDX_FLAGS;
  localparam logic [11:0] A_ENA = stopwatch_pkg::IDX_ENABLES;
  localparam logic [11:0] A_HUN = stopwatch_pkg::IDX_HUND;
  localparam logic [11:0] A_TEN = stopwatch_pkg::IDX_TENTH;
  localparam logic [11:0] A_CTL = stopwatch_pkg::IDX_CTRL;
  logic        sys_clk;
  logic        rst_b;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [13:0] wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic        irq;
  int          n_errors;
  int          samples_checked;
  int          cycles;
  logic [31:0] q;
  longint      t_prev;
  int          gap;
  int          n_short;
  int          total;

  bcd_stopwatch_timer #(.BASE_DIV(BD)) uut (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .wb_cyc   (wb_cyc),
    .wb_stb   (wb_stb),
    .wb_we    (wb_we),
    .wb_adr   (wb_adr),
    .wb_sel   (wb_sel),
    .wb_dat_w (wb_dat_w),
    .wb_dat_r (wb_dat_r),
    .wb_ack   (wb_ack),
    .irq      (irq)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check

  // One classic cycle; the request stands until ack is sampled high.
  task automatic bus(input logic we, input logic [11:0] idx, input logic [3:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= {idx, 2'b00};
    wb_sel   <= 4'hF;
    wb_dat_w <= {28'h0, d};
    do begin
      @(posedge sys_clk);
      n = n + 1;
    end while (wb_ack !== 1'b1 && n < 64);
    r = wb_dat_r;
    check("bus ack", 32'h1, {31'h0, wb_ack});
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : bus

  task automatic rd_check(input string name, input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 4'h0, r);
    check(name, exp, r);
  endtask : rd_check

  // Bounded wait for a level on the interrupt line.
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 400) begin
      @(posedge sys_clk);
      n = n + 1;
    end
    check("irq level", {31'h0, lvl}, {31'h0, irq});
  endtask : wait_irq

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // A stuck handshake must not stall the run forever.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors = n_errors + 1;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0;
    wb_adr = 14'h0000; wb_sel = 4'h0; wb_dat_w = 32'h0;
    n_errors = 0; samples_checked = 0; cycles = 0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd_check("flags", A_FLG, 32'h0);
    rd_check("enables", A_ENA, 32'h0);
    rd_check("hundredths", A_HUN, 32'h0);
    rd_check("tenths", A_TEN, 32'h0);
    rd_check("control", A_CTL, 32'h0);
    rd_check("unmapped", 12'h000, 32'h0);
    bus(1'b1, A_FLG, 4'hF, q);
    bus(1'b1, A_HUN, 4'hF, q);
    bus(1'b1, A_TEN, 4'hF, q);
    bus(1'b1, 12'h000, 4'hF, q);
    rd_check("flags", A_FLG, 32'h0);
    rd_check("hundredths", A_HUN, 32'h0);
    rd_check("tenths", A_TEN, 32'h0);
    bus(1'b1, A_ENA, 4'hF, q);
    rd_check("enables", A_ENA, 32'h3);
    bus(1'b1, A_ENA, 4'h0, q);
    // Run masked: the tenth-second flag rises but the line must stay quiet.
    bus(1'b1, A_CTL, 4'h1, q);
    rd_check("control", A_CTL, 32'h1);
    repeat (300) begin
      @(posedge sys_clk);
      check("masked irq", 32'h0, {31'h0, irq});
    end
    // Stop before reading the hundredths so the digit holds for the check.
    bus(1'b1, A_CTL, 4'h0, q);
    bus(1'b1, A_FLG, 4'h0, q);
    rd_check("flags", A_FLG, 32'h1);
    rd_check("flags", A_FLG, 32'h0);
    bus(1'b0, A_HUN, 4'h0, q);
    repeat (100) @(posedge sys_clk);
    rd_check("held hundredths", A_HUN, q);
    bus(1'b1, A_CTL, 4'h2, q);
    repeat (100) @(posedge sys_clk);
    rd_check("hundredths", A_HUN, 32'h0);
    rd_check("tenths", A_TEN, 32'h0);
    rd_check("control", A_CTL, 32'h0);
    // Clear while running, then time eleven carries through the line.
    bus(1'b1, A_ENA, 4'h1, q);
    bus(1'b1, A_CTL, 4'h3, q);
    t_prev = $time;
    rd_check("control", A_CTL, 32'h1);
    rd_check("tenths", A_TEN, 32'h0);
    n_short = 0;
    total = 0;
    for (int i = 0; i < 11; i++) begin
      wait_irq(1'b1);
      gap = int'(($time - t_prev) / 8);
      if (i == 0) begin
        check("first carry", 32'h1, {31'h0, gap <= 27 * BD + 8});
      end else begin
        check("carry gap", 32'h1, {31'h0, gap == 25 * BD || gap == 26 * BD});
        n_short = n_short + ((gap == 25 * BD) ? 1 : 0);
        total = total + gap;
      end
      t_prev = $time;
      // Before the tenth carry only the one-second source is enabled.
      if (i == 8) begin
        bus(1'b1, A_ENA, 4'h2, q);
        @(posedge sys_clk);
        check("masked tenth irq", 32'h0, {31'h0, irq});
      end
      rd_check("flags", A_FLG, (i == 9) ? 32'h3 : 32'h1);
      wait_irq(1'b0);
      if (i == 9) begin
        bus(1'b1, A_ENA, 4'h1, q);
      end
    end
    check("short cycles", 32'h4, 32'(n_short));
    check("second length", 32'(256 * BD), 32'(total));
    stop_test();
  end

endmodule : bcd_stopwatch_timer_tb

`default_nettype wire
